// *** common/tmc_pkg.sv ***
package tmc_pkg;

   // register offsets, byte wide, high byte of a pair sits one above its low byte
   localparam logic [7:0] TMC_STD_CTL0_OFS = 8'h00;
   localparam logic [7:0] TMC_STD_CTL1_OFS = 8'h01;
   localparam logic [7:0] TMC_STD_CNT_LO_OFS = 8'h02;
   localparam logic [7:0] TMC_STD_CMPA_LO_OFS = 8'h04;
   localparam logic [7:0] TMC_PER_CTL0_OFS = 8'h08;
   localparam logic [7:0] TMC_PER_CTL1_OFS = 8'h09;
   localparam logic [7:0] TMC_PER_CNT_LO_OFS = 8'h0a;
   localparam logic [7:0] TMC_PER_CMPA_LO_OFS = 8'h0c;
   localparam logic [7:0] TMC_PER_CMPP_LO_OFS = 8'h0e;
   localparam logic [7:0] TMC_PINC_OFS = 8'h10;
   localparam logic [7:0] TMC_IRQ_STS_OFS = 8'h11;
   localparam logic [7:0] TMC_IRQ_MSK_OFS = 8'h12;

   // byte pairs, each with its own holding buffer
   localparam int TMC_NPAIR = 5;
   localparam logic [2:0] TMC_PAIR_STD_CNT = 3'h0;
   localparam logic [2:0] TMC_PAIR_STD_CMPA = 3'h1;
   localparam logic [2:0] TMC_PAIR_PER_CNT = 3'h2;
   localparam logic [2:0] TMC_PAIR_PER_CMPA = 3'h3;
   localparam logic [2:0] TMC_PAIR_PER_CMPP = 3'h4;
   localparam logic [2:0] TMC_PAIR_NONE = 3'h7;
   localparam logic [TMC_NPAIR-1:0][7:0] TMC_PAIR_LO_OFS = {TMC_PER_CMPP_LO_OFS,
      TMC_PER_CMPA_LO_OFS, TMC_PER_CNT_LO_OFS, TMC_STD_CMPA_LO_OFS, TMC_STD_CNT_LO_OFS};

   // control fields
   localparam int TMC_C0_PAUSE = 7;
   localparam int TMC_C0_CKS_LSB = 4;
   localparam int TMC_C0_ON = 3;
   localparam int TMC_C0_RP_LSB = 0;
   localparam int TMC_C1_MODE_LSB = 6;
   localparam int TMC_C1_IO_LSB = 4;
   localparam int TMC_C1_OC = 3;
   localparam int TMC_C1_POL = 2;
   localparam int TMC_C1_CCLR = 0;
   localparam int TMC_PINC_CLO = 7;
   localparam int TMC_PINC_PER = 1;
   localparam int TMC_PINC_STD = 0;
   localparam logic [7:0] TMC_PINC_MASK = 8'h83;
   localparam logic [7:0] TMC_CTL_RST = 8'h00;
   localparam logic [7:0] TMC_PINC_RST = 8'h00;

   // interrupt status and mask layout
   localparam int TMC_IRQ_STD_A = 0;
   localparam int TMC_IRQ_STD_P = 1;
   localparam int TMC_IRQ_PER_A = 2;
   localparam int TMC_IRQ_PER_P = 3;

   typedef enum logic [1:0] {TMC_MODE_CMP, TMC_MODE_CAP, TMC_MODE_PWM, TMC_MODE_TMR} tmc_mode_t;
   typedef enum logic [2:0] {TMC_CK_SYS4, TMC_CK_SYS, TMC_CK_HI16, TMC_CK_HI64, TMC_CK_TBC,
      TMC_CK_HI8, TMC_CK_EXT_RISE, TMC_CK_EXT_FALL} tmc_cks_t;

   typedef struct packed {
      logic [9:0] cnt;
      logic out;
      logic on;
      logic ext_q;
      logic cap_q;
   } tmc_core_t;

   typedef struct packed {
      logic [1:0][7:0] ctl0;
      logic [1:0][7:0] ctl1;
      logic [1:0][9:0] cmpa;
      logic [9:0] cmpp;
      logic [7:0] pinc;
      logic [3:0] sts;
      logic [3:0] msk;
      logic [TMC_NPAIR-1:0][7:0] hold;
      logic [5:0] presc;
      logic [7:0] rdata;
   } tmc_regs_t;

endpackage

// *** verilog/tmc_timer.sv ***
`timescale 1ns/10ps
module tmc_timer
   import tmc_pkg::*;
#(
   parameter bit PERIODIC = 1'b0
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // settings
   input wire logic [7:0] ctl0,
   input wire logic [7:0] ctl1,
   input wire logic [9:0] cmp_a,
   input wire logic [9:0] cmp_p,
   input wire logic [5:0] div_tick,
   // pins
   input wire logic ext_clk_pin,
   input wire logic cap_pin,
   // state and events
   output logic [9:0] cnt,
   output logic out_lvl,
   output logic a_hit,
   output logic p_hit,
   output logic cap_evt
);

   tmc_core_t s_r;
   tmc_core_t s_nxt;
   tmc_cks_t cks;
   tmc_mode_t mode;
   logic [1:0] io;
   logic run;
   logic tick;
   logic ext_rise;
   logic ext_fall;
   logic cap_rise;
   logic cap_fall;
   logic cap_sel;
   logic pwm_lvl;
   logic [9:0] inc;
   logic [9:0] p_val;

   assign cnt = s_r.cnt;
   assign out_lvl = s_r.out;

   always_comb
   begin
      s_nxt = s_r;
      cks = tmc_cks_t'(ctl0[TMC_C0_CKS_LSB+:3]);
      mode = tmc_mode_t'(ctl1[TMC_C1_MODE_LSB+:2]);
      io = ctl1[TMC_C1_IO_LSB+:2];
      run = ctl0[TMC_C0_ON] && !ctl0[TMC_C0_PAUSE];
      ext_rise = ext_clk_pin && !s_r.ext_q;
      ext_fall = !ext_clk_pin && s_r.ext_q;
      cap_rise = cap_pin && !s_r.cap_q;
      cap_fall = !cap_pin && s_r.cap_q;
      case (cks)
         TMC_CK_EXT_RISE: tick = ext_rise;
         TMC_CK_EXT_FALL: tick = ext_fall;
         default: tick = div_tick[cks];
      endcase
      inc = s_r.cnt + 10'h001;
      // standard type compares the whole count with its three period bits over seven zero bits, zero meaning full wrap
      p_val = PERIODIC ? cmp_p : {ctl0[TMC_C0_RP_LSB+:3], 7'h00};
      a_hit = run && tick && (inc == cmp_a);
      p_hit = run && tick && (inc == p_val);
      if (run && tick)
      begin
         s_nxt.cnt = (ctl1[TMC_C1_CCLR] ? a_hit : p_hit) ? 10'h000 : inc;
      end
      case (io)
         2'b00: cap_sel = cap_rise;
         2'b01: cap_sel = cap_fall;
         2'b10: cap_sel = cap_rise || cap_fall;
         default: cap_sel = 1'b0;
      endcase
      // the periodic type may also be triggered from its clock pin
      if (PERIODIC && io != 2'b11)
      begin
         cap_sel = cap_sel || (io[0] ? ext_fall : ext_rise) || (io[1] && ext_fall);
      end
      cap_evt = ctl0[TMC_C0_ON] && (mode == TMC_MODE_CAP) && cap_sel;
      pwm_lvl = (s_r.cnt < cmp_a);
      case (mode)
         TMC_MODE_CMP:
         begin
            if (a_hit)
            begin
               case (io)
                  2'b01: s_nxt.out = 1'b0;
                  2'b10: s_nxt.out = 1'b1;
                  2'b11: s_nxt.out = !s_r.out;
                  default: s_nxt.out = s_r.out;
               endcase
            end
         end
         TMC_MODE_PWM:
         begin
            case (io)
               2'b00: s_nxt.out = ctl1[TMC_C1_POL];
               2'b01: s_nxt.out = !ctl1[TMC_C1_POL];
               default: s_nxt.out = pwm_lvl ^ ctl1[TMC_C1_POL];
            endcase
         end
         default: s_nxt.out = s_r.out;
      endcase
      // switching on restarts the count and the output from its initial level
      if (ctl0[TMC_C0_ON] && !s_r.on)
      begin
         s_nxt.cnt = 10'h000;
         s_nxt.out = ctl1[TMC_C1_OC];
      end
      s_nxt.on = ctl0[TMC_C0_ON];
      s_nxt.ext_q = ext_clk_pin;
      s_nxt.cap_q = cap_pin;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_ext_rise_count;
      (cks == TMC_CK_EXT_RISE) && run && s_r.on && ext_rise && !a_hit && !p_hit
         |=> (s_r.cnt == $past(inc));
   endproperty
   a_ext_rise_count: assert property (p_ext_rise_count)
      else $error("counter missed a rising edge of the clock pin");

   property p_toggle;
      (mode == TMC_MODE_CMP) && (io == 2'b11) && a_hit && s_r.on |=> (s_r.out != $past(s_r.out));
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("output did not toggle on compare match");

endmodule

// *** verilog/tmc_top.sv ***
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
module tmc_top
   import tmc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // timebase clock, one-cycle tick
   input wire logic tbc_tick,
   // timer input pins
   input wire logic std_ext_clock_pin,
   input wire logic per_ext_clock_pin,
   input wire logic std_capture_pin,
   input wire logic per_capture_pin,
   // other shared functions of the output pins
   input wire logic std_out_alt,
   input wire logic std_out_alt_oe,
   input wire logic per_out_alt,
   input wire logic per_out_alt_oe,
   input wire logic clo_src,
   input wire logic clo_alt,
   input wire logic clo_alt_oe,
   // output pins
   output logic std_output_pin,
   output logic std_output_pin_oe,
   output logic per_output_pin,
   output logic per_output_pin_oe,
   output logic clock_output_pin,
   output logic clock_output_pin_oe,
   // interrupt
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic [2:0] tmc_pair_of(input logic [7:0] a);
      logic [2:0] idx;
      idx = TMC_PAIR_NONE;
      for (int i = 0; i < TMC_NPAIR; i++)
      begin
         if (a[7:1] == TMC_PAIR_LO_OFS[i][7:1])
         begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   // timer owns the pin only when routed, on, and in a mode that drives
   function automatic logic tmc_drives(input logic route, input logic [7:0] c0,
      input logic [7:0] c1);
      tmc_mode_t m;
      m = tmc_mode_t'(c1[TMC_C1_MODE_LSB+:2]);
      return route && c0[TMC_C0_ON] && (m == TMC_MODE_CMP || m == TMC_MODE_PWM);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // state

   tmc_regs_t regs_r;
   tmc_regs_t regs_nxt;
   logic [5:0] div_tick;
   logic [1:0][9:0] cnt;
   logic [1:0] out_lvl;
   logic [1:0] a_hit;
   logic [1:0] p_hit;
   logic [1:0] cap_evt;
   logic [1:0] ext_pin;
   logic [1:0] cap_pin;
   logic [TMC_NPAIR-1:0][7:0] pair_lo;
   logic [TMC_NPAIR-1:0][1:0] pair_hi;
   logic [2:0] pidx;
   logic [3:0] evt;
   logic [3:0] clr;
   logic std_drv;
   logic per_drv;

   ////////////////////////////////////////////////////////////////////////////////
   // the two timers

   assign ext_pin = {per_ext_clock_pin, std_ext_clock_pin};
   assign cap_pin = {per_capture_pin, std_capture_pin};

   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_tmr
         tmc_timer #(
            .PERIODIC(g == 1)
         ) u_tmr (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .ctl0(regs_r.ctl0[g]),
            .ctl1(regs_r.ctl1[g]),
            .cmp_a(regs_r.cmpa[g]),
            .cmp_p(regs_r.cmpp),
            .div_tick(div_tick),
            .ext_clk_pin(ext_pin[g]),
            .cap_pin(cap_pin[g]),
            .cnt(cnt[g]),
            .out_lvl(out_lvl[g]),
            .a_hit(a_hit[g]),
            .p_hit(p_hit[g]),
            .cap_evt(cap_evt[g])
         );
      end
   endgenerate

   // internal high clock is taken as the core clock; one shared prescaler
   always_comb
   begin
      div_tick[TMC_CK_SYS4] = (regs_r.presc[1:0] == 2'h3);
      div_tick[TMC_CK_SYS] = 1'b1;
      div_tick[TMC_CK_HI16] = (regs_r.presc[3:0] == 4'hf);
      div_tick[TMC_CK_HI64] = (regs_r.presc == 6'h3f);
      div_tick[TMC_CK_TBC] = tbc_tick;
      div_tick[TMC_CK_HI8] = (regs_r.presc[2:0] == 3'h7);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // byte pair views

   always_comb
   begin
      pair_lo[TMC_PAIR_STD_CNT] = cnt[0][7:0];
      pair_hi[TMC_PAIR_STD_CNT] = cnt[0][9:8];
      pair_lo[TMC_PAIR_STD_CMPA] = regs_r.cmpa[0][7:0];
      pair_hi[TMC_PAIR_STD_CMPA] = regs_r.cmpa[0][9:8];
      pair_lo[TMC_PAIR_PER_CNT] = cnt[1][7:0];
      pair_hi[TMC_PAIR_PER_CNT] = cnt[1][9:8];
      pair_lo[TMC_PAIR_PER_CMPA] = regs_r.cmpa[1][7:0];
      pair_hi[TMC_PAIR_PER_CMPA] = regs_r.cmpa[1][9:8];
      pair_lo[TMC_PAIR_PER_CMPP] = regs_r.cmpp[7:0];
      pair_hi[TMC_PAIR_PER_CMPP] = regs_r.cmpp[9:8];
   end

   assign pidx = tmc_pair_of(reg_addr);
   assign evt = {p_hit[1], a_hit[1] || cap_evt[1], p_hit[0], a_hit[0] || cap_evt[0]};

   ////////////////////////////////////////////////////////////////////////////////
   // register file

   always_comb
   begin
      regs_nxt = regs_r;
      regs_nxt.presc = regs_r.presc + 6'h01;
      regs_nxt.rdata = 8'h00;
      clr = 4'h0;
      if (reg_wr)
      begin
         if (pidx != TMC_PAIR_NONE)
         begin
            // counter pairs are read-only, their writes fall away
            if (pidx != TMC_PAIR_STD_CNT && pidx != TMC_PAIR_PER_CNT)
            begin
               if (!reg_addr[0])
               begin
                  regs_nxt.hold[pidx] = reg_wdata;
               end
               else if (pidx == TMC_PAIR_STD_CMPA)
               begin
                  regs_nxt.cmpa[0] = {reg_wdata[1:0], regs_r.hold[pidx]};
               end
               else if (pidx == TMC_PAIR_PER_CMPA)
               begin
                  regs_nxt.cmpa[1] = {reg_wdata[1:0], regs_r.hold[pidx]};
               end
               else
               begin
                  regs_nxt.cmpp = {reg_wdata[1:0], regs_r.hold[pidx]};
               end
            end
         end
         else if (reg_addr == TMC_STD_CTL0_OFS)
         begin
            regs_nxt.ctl0[0] = reg_wdata;
         end
         else if (reg_addr == TMC_STD_CTL1_OFS)
         begin
            regs_nxt.ctl1[0] = reg_wdata;
         end
         else if (reg_addr == TMC_PER_CTL0_OFS)
         begin
            regs_nxt.ctl0[1] = reg_wdata;
         end
         else if (reg_addr == TMC_PER_CTL1_OFS)
         begin
            regs_nxt.ctl1[1] = reg_wdata;
         end
         else if (reg_addr == TMC_PINC_OFS)
         begin
            regs_nxt.pinc = reg_wdata & TMC_PINC_MASK;
         end
         else if (reg_addr == TMC_IRQ_STS_OFS)
         begin
            clr = reg_wdata[3:0];
         end
         else if (reg_addr == TMC_IRQ_MSK_OFS)
         begin
            regs_nxt.msk = reg_wdata[3:0];
         end
      end
      if (reg_rd)
      begin
         if (pidx != TMC_PAIR_NONE)
         begin
            if (reg_addr[0])
            begin
               regs_nxt.rdata = {6'h00, pair_hi[pidx]};
               regs_nxt.hold[pidx] = pair_lo[pidx];
            end
            else
            begin
               regs_nxt.rdata = regs_r.hold[pidx];
            end
         end
         else if (reg_addr == TMC_STD_CTL0_OFS)
         begin
            regs_nxt.rdata = regs_r.ctl0[0];
         end
         else if (reg_addr == TMC_STD_CTL1_OFS)
         begin
            regs_nxt.rdata = regs_r.ctl1[0];
         end
         else if (reg_addr == TMC_PER_CTL0_OFS)
         begin
            regs_nxt.rdata = regs_r.ctl0[1];
         end
         else if (reg_addr == TMC_PER_CTL1_OFS)
         begin
            regs_nxt.rdata = regs_r.ctl1[1];
         end
         else if (reg_addr == TMC_PINC_OFS)
         begin
            regs_nxt.rdata = regs_r.pinc;
         end
         else if (reg_addr == TMC_IRQ_STS_OFS)
         begin
            regs_nxt.rdata = {4'h0, regs_r.sts};
         end
         else if (reg_addr == TMC_IRQ_MSK_OFS)
         begin
            regs_nxt.rdata = {4'h0, regs_r.msk};
         end
      end
      // capture lands after software so the captured count is never lost
      if (cap_evt[0])
      begin
         regs_nxt.cmpa[0] = cnt[0];
      end
      if (cap_evt[1])
      begin
         regs_nxt.cmpa[1] = cnt[1];
      end
      // a new event beats a clear in the same cycle
      regs_nxt.sts = (regs_r.sts & ~clr) | evt;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         regs_r <= '0;
      end
      else
      begin
         regs_r <= regs_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs and pin routing

   assign reg_rdata = regs_r.rdata;
   assign irq = |(regs_r.sts & regs_r.msk);
   assign std_drv = tmc_drives(regs_r.pinc[TMC_PINC_STD], regs_r.ctl0[0], regs_r.ctl1[0]);
   assign per_drv = tmc_drives(regs_r.pinc[TMC_PINC_PER], regs_r.ctl0[1], regs_r.ctl1[1]);

   always_comb
   begin
      std_output_pin = std_drv ? out_lvl[0] : std_out_alt;
      std_output_pin_oe = std_drv ? 1'b1 : std_out_alt_oe;
      per_output_pin = per_drv ? out_lvl[1] : per_out_alt;
      per_output_pin_oe = per_drv ? 1'b1 : per_out_alt_oe;
      clock_output_pin = regs_r.pinc[TMC_PINC_CLO] ? clo_src : clo_alt;
      clock_output_pin_oe = regs_r.pinc[TMC_PINC_CLO] ? 1'b1 : clo_alt_oe;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_match_irq;
      // a mask write in the match cycle legally keeps the line low
      a_hit[0] && regs_r.msk[TMC_IRQ_STD_A] && !(reg_wr && reg_addr == TMC_IRQ_MSK_OFS)
         |=> irq && regs_r.sts[TMC_IRQ_STD_A];
   endproperty
   a_match_irq: assert property (p_match_irq)
      else $error("comparator A match did not raise the interrupt");

   property p_clear_on_a;
      a_hit[0] && regs_r.ctl1[0][TMC_C1_CCLR] && regs_r.ctl0[0][TMC_C0_ON] |=> cnt[0] == 10'h000;
   endproperty
   a_clear_on_a: assert property (p_clear_on_a)
      else $error("counter not cleared on comparator A match");

   property p_pinc_reserved;
      reg_rd && reg_addr == TMC_PINC_OFS |=> reg_rdata[6:2] == 5'h00;
   endproperty
   a_pinc_reserved: assert property (p_pinc_reserved)
      else $error("unused pin-control bits read nonzero");

   property p_low_write_buf_only;
      reg_wr && reg_addr == TMC_STD_CMPA_LO_OFS && !cap_evt[0]
         |=> $stable(regs_r.cmpa[0]) && regs_r.hold[TMC_PAIR_STD_CMPA] == $past(reg_wdata);
   endproperty
   a_low_write_buf_only: assert property (p_low_write_buf_only)
      else $error("low byte write reached the register");

   property p_high_write_copies;
      reg_wr && reg_addr == TMC_PER_CMPP_LO_OFS + 8'h01
         |=> regs_r.cmpp == {$past(reg_wdata[1:0]), $past(regs_r.hold[TMC_PAIR_PER_CMPP])};
   endproperty
   a_high_write_copies: assert property (p_high_write_copies)
      else $error("high byte write did not copy the buffer");

   property p_high_read_latch;
      reg_rd && reg_addr == TMC_STD_CNT_LO_OFS + 8'h01
         |=> regs_r.hold[TMC_PAIR_STD_CNT] == $past(cnt[0][7:0])
            && reg_rdata == {6'h00, $past(cnt[0][9:8])};
   endproperty
   a_high_read_latch: assert property (p_high_read_latch)
      else $error("high byte read did not latch the low byte");

   property p_low_read_buf;
      reg_rd && reg_addr == TMC_PER_CNT_LO_OFS
         |=> reg_rdata == $past(regs_r.hold[TMC_PAIR_PER_CNT]);
   endproperty
   a_low_read_buf: assert property (p_low_read_buf)
      else $error("low byte read did not return the buffer");

   property p_route_off;
      !regs_r.pinc[TMC_PINC_STD] |-> std_output_pin == std_out_alt
         && std_output_pin_oe == std_out_alt_oe;
   endproperty
   a_route_off: assert property (p_route_off)
      else $error("unrouted pin not left to its other function");

   property p_own_buffer;
      reg_wr && reg_addr == TMC_STD_CMPA_LO_OFS ##1 reg_rd && reg_addr == TMC_PER_CNT_LO_OFS + 8'h01
         |=> regs_r.hold[TMC_PAIR_STD_CMPA] == $past(reg_wdata, 2);
   endproperty
   a_own_buffer: assert property (p_own_buffer)
      else $error("one pair disturbed the buffer of another");

   c_per_p_match: cover property (p_hit[1] ##1 irq);
   c_capture: cover property (cap_evt[1]);
   c_pair_write: cover property (reg_wr && reg_addr == TMC_STD_CMPA_LO_OFS
      ##1 reg_wr && reg_addr == TMC_STD_CMPA_LO_OFS + 8'h01);

endmodule

// *** tb/tmc_top_tb.sv ***
`timescale 1ns/10ps
module tmc_top_tb;
   import tmc_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sck = 1'b0;
   logic pck = 1'b0;
   logic pcp = 1'b0;
   logic [6:0] alt = 7'h00;
   logic [7:0] reg_rdata;
   logic so, soe, po, poe, co, coe, irq, b;
   logic [7:0] d;
   logic [7:0] lo [5];
   logic [7:0] hi [5];
   int error_cnt = 0;
   int comparisons = 0;
   int seed = 91;
   int k, p;

   always #2.5 core_clk = ~core_clk;

   // timebase held still so a capture test counter stays at zero
   tmc_top tmc_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tbc_tick(1'b0), .std_ext_clock_pin(sck), .per_ext_clock_pin(pck),
      .std_capture_pin(1'b0), .per_capture_pin(pcp), .std_out_alt(alt[0]),
      .std_out_alt_oe(alt[1]), .per_out_alt(alt[2]), .per_out_alt_oe(alt[3]),
      .clo_src(alt[4]), .clo_alt(alt[5]), .clo_alt_oe(alt[6]), .std_output_pin(so),
      .std_output_pin_oe(soe), .per_output_pin(po), .per_output_pin_oe(poe),
      .clock_output_pin(co), .clock_output_pin_oe(coe), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] pinc_exp(input logic [7:0] v);
      return {v[7], 5'h00, v[1:0]};
   endfunction

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(n, e, reg_rdata);
   endtask

   // other functions must show through at the clock output and periodic pins wherever the timer does not own them
   task automatic route(input logic [7:0] pc);
      @(posedge core_clk);
      alt <= 7'($random(seed));
      @(posedge core_clk);
      #1 chk("clo_pin", pc[7] ? {7'h01, alt[4]} : {6'h00, alt[6:5]}, {6'h00, coe, co});
      chk("per_pin", {6'h00, alt[3:2]}, {6'h00, poe, po});
   endtask

   task automatic conclude;
      $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      rchk("pinc_rst", TMC_PINC_OFS, 8'h00);
      rchk("sts_rst", TMC_IRQ_STS_OFS, 8'h00);
      route(8'h00);
      d = 8'($random(seed));
      wr(TMC_PINC_OFS, d);
      rchk("pinc", TMC_PINC_OFS, pinc_exp(d));
      wr(TMC_PINC_OFS, 8'h83);
      route(8'h83);
      wr(8'h20, 8'hff);
      rchk("unmapped", 8'h20, 8'h00);
      $display("test done: pin control");
      // all lows first so a shared buffer would lose data
      for (int j = 0; j < 5; j++)
      begin
         lo[j] = 8'($random(seed));
         hi[j] = 8'($random(seed));
      end
      for (int j = 0; j < 3; j++)
      begin
         p = (j == 0) ? 1 : j + 2;
         wr(TMC_PAIR_LO_OFS[p], lo[p]);
      end
      for (int j = 0; j < 3; j++)
      begin
         p = (j == 0) ? 1 : j + 2;
         wr(TMC_PAIR_LO_OFS[p] + 8'h01, hi[p]);
      end
      for (int j = 0; j < 3; j++)
      begin
         p = (j == 0) ? 1 : j + 2;
         rchk("pair_hi", TMC_PAIR_LO_OFS[p] + 8'h01, {6'h00, hi[p][1:0]});
      end
      for (int j = 0; j < 3; j++)
      begin
         p = (j == 0) ? 1 : j + 2;
         rchk("pair_lo", TMC_PAIR_LO_OFS[p], lo[p]);
      end
      $display("test done: byte pairs");
      wr(TMC_STD_CMPA_LO_OFS, 8'h00);
      wr(TMC_STD_CMPA_LO_OFS + 8'h01, 8'h00);
      for (int s = 0; s < 2; s++)
      begin
         k = ($random(seed) & 31) + 1;
         wr(TMC_STD_CTL0_OFS, 8'h00);
         wr(TMC_STD_CTL0_OFS, s ? 8'h78 : 8'h68);
         repeat (k)
         begin
            @(posedge core_clk) sck <= 1'b1;
            @(posedge core_clk) sck <= 1'b0;
         end
         repeat (3) @(posedge core_clk);
         wr(TMC_STD_CTL0_OFS, s ? 8'hf8 : 8'he8);
         rchk("cnt_hi", TMC_STD_CNT_LO_OFS + 8'h01, 8'h00);
         rchk("cnt_lo", TMC_STD_CNT_LO_OFS, k[7:0]);
      end
      $display("test done: event counting");
      wr(TMC_STD_CTL0_OFS, 8'h00);
      wr(TMC_STD_CMPA_LO_OFS, 8'h05);
      wr(TMC_STD_CMPA_LO_OFS + 8'h01, 8'h00);
      wr(TMC_STD_CTL1_OFS, 8'h31);
      wr(TMC_IRQ_MSK_OFS, 8'h01);
      wr(TMC_STD_CTL0_OFS, 8'h18);
      repeat (20) @(posedge core_clk);
      #1 b = so;
      chk("std_oe", 8'h01, {7'h00, soe});
      repeat (5) @(posedge core_clk);
      #1 chk("toggle", {7'h00, ~b}, {7'h00, so});
      chk("irq_on", 8'h01, {7'h00, irq});
      rchk("sts_a", TMC_IRQ_STS_OFS, 8'h01);
      wr(TMC_IRQ_MSK_OFS, 8'h00);
      #1 chk("irq_masked", 8'h00, {7'h00, irq});
      wr(TMC_STD_CTL0_OFS, 8'h00);
      wr(TMC_IRQ_STS_OFS, 8'h01);
      rchk("sts_clr", TMC_IRQ_STS_OFS, 8'h00);
      $display("test done: compare match");
      wr(TMC_PER_CTL0_OFS, 8'h48);
      for (int io = 0; io < 3; io++)
      begin
         wr(TMC_PER_CTL1_OFS, {2'b01, 2'(io), 4'h0});
         wr(TMC_IRQ_STS_OFS, 8'h0f);
         @(posedge core_clk) pcp <= 1'b1;
         repeat (3) @(posedge core_clk);
         rchk("cap_rise", TMC_IRQ_STS_OFS, (io != 1) ? 8'h04 : 8'h00);
         wr(TMC_IRQ_STS_OFS, 8'h04);
         @(posedge core_clk) pcp <= 1'b0;
         repeat (3) @(posedge core_clk);
         rchk("cap_fall", TMC_IRQ_STS_OFS, (io != 0) ? 8'h04 : 8'h00);
      end
      wr(TMC_PER_CTL1_OFS, 8'h40);
      wr(TMC_IRQ_STS_OFS, 8'h0f);
      @(posedge core_clk) pck <= 1'b1;
      repeat (3) @(posedge core_clk);
      rchk("cap_clk_pin", TMC_IRQ_STS_OFS, 8'h04);
      // both-edge setting must also take a falling clock-pin edge
      wr(TMC_PER_CTL1_OFS, 8'h60);
      wr(TMC_IRQ_STS_OFS, 8'h0f);
      @(posedge core_clk) pck <= 1'b0;
      repeat (3) @(posedge core_clk);
      rchk("cap_clk_both", TMC_IRQ_STS_OFS, 8'h04);
      route(8'h83);
      $display("test done: capture");
      // pwm idle and active levels, timer now owns the periodic pin
      wr(TMC_PER_CTL1_OFS, 8'h84);
      @(posedge core_clk);
      #1 chk("pwm_idle", 8'h03, {6'h00, poe, po});
      wr(TMC_PER_CTL1_OFS, 8'h94);
      @(posedge core_clk);
      #1 chk("pwm_active", 8'h02, {6'h00, poe, po});
      $display("test done: pwm");
      conclude();
   end

   initial
   begin
      #100000;
      error_cnt++;
      conclude();
   end
endmodule
